// File: rtc_relay_ctrl.sv
// Relay and indicator controller for one output of a panel meter, with APB registers.
//
// Behaviour
// - Inactive mode keeps relay de-energised, except under a force-on or keep-state alarm.
// - Direct mode: on above T1+H, off below T1-H.
// - Inverse mode: off above T1+H, on below.
// - Inside mode: on between lower+H and upper-H.
// - Outside mode: off beyond the outer borders.
// - Larger threshold is upper, order irrelevant.
// - Thresholds -999..9999, hysteresis 0..999, band twice.
// - Second threshold used only in dual modes.
// - Bus mode follows bus commands, ignores input.
// - Bus relay command is volatile, reset clears.
// - LED lit exactly while relay is closed.
// - Switch on only after turn-on delay.
// - Switch off only after turn-off delay.
// - Early return leaves relay state unchanged.
// - Time base selects seconds or minutes.
// - Critical situation applies keep, on or off.
// - Threshold modes: out of range is critical.
// - Bus mode: frame gap over timeout critical.
// - Force-on works even in inactive mode.
// - Lower border: minimum less per mille expansion, zero-based zero.
// - Upper border: maximum plus per mille expansion.
// - Compare current result or held peak.
// - Bus timeout 0..99 s, zero disables.
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_relay_ctrl
   import rtc_pkg::*;
#(
   parameter int unsigned TENTH_CYCLES = 32'(`RTC_TENTH_CYCLES)  // Clock cycles in 0.1 s.
) (
   input  wire logic               ref_clk,       // System clock, 40 MHz.
   input  wire logic               reset_n,       // Synchronous reset, active low.
   input  wire logic               psel,          // APB select.
   input  wire logic               penable,       // APB access phase.
   input  wire logic               pwrite,        // APB direction, high for write.
   input  wire logic [7:0]         paddr,         // APB byte address.
   input  wire logic [31:0]        pwdata,        // APB write data.
   output logic      [31:0]        prdata,        // APB read data.
   output logic                    pready,        // APB ready.
   output logic                    pslverr,       // APB error on unmapped address.
   input  wire logic signed [15:0] meas_result,   // Scaled current result.
   input  wire logic signed [15:0] meas_peak,     // Held peak or drop value.
   input  wire logic               peak_active,   // Peak detection is running.
   input  wire logic [15:0]        input_level,   // Raw input level in range units.
   output logic                    relay_out,     // Relay drive, high energises.
   output logic                    relay_led      // Output indicator LED.
);

   // ======================================================================
   // Register state.
   rtc_mode_t          mode_q;        // Output mode.
   rtc_alarm_t         alarm_q;       // Reaction to a critical situation.
   logic               minutes_q;     // Delay time base, high for minutes.
   logic               use_peak_q;    // Compare against the peak value.
   logic               zero_base_q;   // Input type starts at zero.
   logic signed [15:0] thr1_q;        // First threshold.
   logic signed [15:0] thr2_q;        // Second threshold.
   logic [9:0]         hysteresis_half_width_q;        // Hysteresis half width.
   logic [9:0]         on_dly_q;      // Turn-on delay in tenths of a unit.
   logic [9:0]         off_dly_q;     // Turn-off delay in tenths of a unit.
   logic [9:0]         lo_exp_q;      // Low range expansion, per mille.
   logic [9:0]         hi_exp_q;      // High range expansion, per mille.
   logic [15:0]        nom_min_q;     // Nominal live-zero minimum.
   logic [15:0]        nom_max_q;     // Nominal maximum.
   logic               bus_cmd_q;     // Relay state commanded over the bus.
   logic [6:0]         bus_to_q;      // Bus frame timeout in seconds.
   logic               relay_q;       // Relay state.
   logic               led_q;         // Indicator state.

   // ======================================================================
   // APB decode. The slave always answers in the access phase.
   logic        setup_ph;      // Setup phase of a transfer.
   logic        access_ph;     // Access phase of a transfer.
   logic        wr_en;         // Write takes effect this edge.
   logic        mapped;        // Address hits a register.
   logic        frame_rx;      // A bus frame write arrived.
   logic [31:0] rd_mux;        // Read data selected by address.

   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign wr_en     = access_ph && pwrite && mapped;
   assign frame_rx  = wr_en && (paddr == `RTC_OFS_BUSCMD);
   assign pready    = 1'b1;
   assign pslverr   = access_ph && !mapped;

   // Address decode covers every register, status read-only.
   always_comb begin
      case (paddr)
         `RTC_OFS_CTRL, `RTC_OFS_THR1, `RTC_OFS_THR2, `RTC_OFS_HYSTERESIS_HALF_WIDTH,
         `RTC_OFS_DELAY, `RTC_OFS_RANGE, `RTC_OFS_NOMINAL,
         `RTC_OFS_BUSCMD, `RTC_OFS_STATUS: mapped = 1'b1;
         default:                          mapped = 1'b0;
      endcase
   end

   // Settings registers; thresholds, hysteresis, delays, expansions and bus timeout clamp to their limits, other fields store as written.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         mode_q      <= RTC_OUTPUT_INACTIVE;
         alarm_q     <= RTC_KEEP_STATE;
         minutes_q   <= 1'b0;
         use_peak_q  <= 1'b0;
         zero_base_q <= 1'b0;
         thr1_q      <= 16'sh0000;
         thr2_q      <= 16'sh0000;
         hysteresis_half_width_q      <= 10'h000;
         on_dly_q    <= 10'h000;
         off_dly_q   <= 10'h000;
         lo_exp_q    <= 10'h000;
         hi_exp_q    <= 10'h000;
         nom_min_q   <= `RTC_NOM_MIN_RST;
         nom_max_q   <= `RTC_NOM_MAX_RST;
         bus_to_q    <= 7'h00;
      end else if (wr_en) begin
         case (paddr)
            `RTC_OFS_CTRL: begin
               mode_q      <= rtc_mode_t'(pwdata[`RTC_CTRL_MODE_LSB +: 3]);
               alarm_q     <= rtc_alarm_t'(pwdata[`RTC_CTRL_ALARM_LSB +: 2]);
               minutes_q   <= pwdata[`RTC_CTRL_MINUTES];
               use_peak_q  <= pwdata[`RTC_CTRL_PEAK];
               zero_base_q <= pwdata[`RTC_CTRL_ZEROBASE];
            end
            `RTC_OFS_THR1: thr1_q <= clamp_thr(pwdata[15:0]);
            `RTC_OFS_THR2: thr2_q <= clamp_thr(pwdata[15:0]);
            `RTC_OFS_HYSTERESIS_HALF_WIDTH: hysteresis_half_width_q <= clamp10(pwdata[9:0], `RTC_HYSTERESIS_HALF_WIDTH_MAX);
            `RTC_OFS_DELAY: begin
               on_dly_q  <= clamp10(pwdata[9:0], `RTC_DELAY_MAX);
               off_dly_q <= clamp10(pwdata[`RTC_HI_FIELD_LSB +: 10], `RTC_DELAY_MAX);
            end
            `RTC_OFS_RANGE: begin
               lo_exp_q <= clamp10(pwdata[9:0], `RTC_LO_EXP_MAX);
               hi_exp_q <= clamp10(pwdata[`RTC_HI_FIELD_LSB +: 10], `RTC_HI_EXP_MAX);
            end
            `RTC_OFS_NOMINAL: begin
               nom_min_q <= pwdata[15:0];
               nom_max_q <= pwdata[`RTC_HI_FIELD_LSB +: 16];
            end
            `RTC_OFS_BUSCMD: begin
               bus_to_q <= (pwdata[`RTC_BUS_TIMEOUT_LSB +: 7] > `RTC_TIMEOUT_MAX) ?
                           `RTC_TIMEOUT_MAX : pwdata[`RTC_BUS_TIMEOUT_LSB +: 7];
            end
            default: ;
         endcase
      end
   end

   // Clamps a threshold to its allowed span.
   function automatic logic signed [15:0] clamp_thr(input logic signed [15:0] s);
      clamp_thr = (s < 16'(`RTC_THR_MIN)) ? 16'(`RTC_THR_MIN) :
                  (s > 16'(`RTC_THR_MAX)) ? 16'(`RTC_THR_MAX) : s;
   endfunction

   // Clamps a ten-bit setting to its upper limit.
   function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lim);
      clamp10 = (v > lim) ? lim : v;
   endfunction

   // The bus command lives only in a flip-flop and is lost at reset.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         bus_cmd_q <= 1'b0;
      end else if (frame_rx) begin
         bus_cmd_q <= pwdata[0];
      end
   end

   // ======================================================================
   // Permissible range check.
   logic [25:0] lo_cut;      // Minimum times low expansion.
   logic [25:0] hi_add;      // Maximum times high expansion.
   logic [16:0] lo_border;   // Lower permissible border.
   logic [16:0] hi_border;   // Upper permissible border.
   logic        out_of_range;// Input outside the permissible range.

   assign lo_cut    = nom_min_q * lo_exp_q;
   assign hi_add    = nom_max_q * hi_exp_q;
   assign lo_border = zero_base_q ? 17'h00000 :
                      17'({1'b0, nom_min_q} - 17'(lo_cut / `RTC_PER_MILLE));
   assign hi_border = 17'({1'b0, nom_max_q} + 17'(hi_add / `RTC_PER_MILLE));
   assign out_of_range = ({1'b0, input_level} < lo_border) ||
                         ({1'b0, input_level} > hi_border);

   // ======================================================================
   // Threshold comparison with hysteresis.
   logic signed [17:0] x;        // Value being compared.
   logic signed [17:0] t_hi;     // Upper threshold.
   logic signed [17:0] t_lo;     // Lower threshold.
   logic signed [17:0] h;        // Hysteresis half width.
   logic               on_cond;  // Input beyond the switch-on border.
   logic               off_cond; // Input beyond the switch-off border.
   logic               thr_mode; // Mode is threshold based.

   assign x    = (use_peak_q && peak_active) ? 18'(meas_peak) : 18'(meas_result);
   assign t_hi = (thr1_q > thr2_q) ? 18'(thr1_q) : 18'(thr2_q);
   assign t_lo = (thr1_q > thr2_q) ? 18'(thr2_q) : 18'(thr1_q);
   assign h    = signed'({8'h00, hysteresis_half_width_q});
   assign thr_mode = (mode_q == RTC_SINGLE_DIRECT) || (mode_q == RTC_SINGLE_INVERSE) ||
                     (mode_q == RTC_DUAL_INSIDE)   || (mode_q == RTC_DUAL_OUTSIDE);

   // Picks the switch-on and switch-off conditions for the mode.
   always_comb begin
      on_cond  = 1'b0;
      off_cond = 1'b0;
      case (mode_q)
         RTC_SINGLE_DIRECT: begin
            on_cond  = x > 18'(thr1_q) + h;
            off_cond = x < 18'(thr1_q) - h;
         end
         RTC_SINGLE_INVERSE: begin
            off_cond = x > 18'(thr1_q) + h;
            on_cond  = x < 18'(thr1_q) - h;
         end
         RTC_DUAL_INSIDE: begin
            on_cond  = (x > t_lo + h) && (x < t_hi - h);
            off_cond = (x < t_lo - h) || (x > t_hi + h);
         end
         RTC_DUAL_OUTSIDE: begin
            off_cond = (x < t_lo - h) || (x > t_hi + h);
            on_cond  = (x > t_lo + h) && (x < t_hi - h);
         end
         default: ;
      endcase
   end

   // ======================================================================
   // Bus frame gap supervision, counted in cycles, tenths and seconds since the last frame.
   logic [31:0] gap_pre_q;   // Cycles within a tenth.
   logic [3:0]  gap_ten_q;   // Tenths within a second.
   logic [6:0]  gap_sec_q;   // Seconds since the last frame.
   logic        bus_late;    // Gap exceeds the timeout.

   always_ff @(posedge ref_clk) begin
      if (!reset_n || frame_rx) begin
         gap_pre_q <= 32'h0000_0000;
         gap_ten_q <= 4'h0;
         gap_sec_q <= 7'h00;
      end else if (gap_pre_q == 32'(TENTH_CYCLES - 1)) begin
         gap_pre_q <= 32'h0000_0000;
         if (gap_ten_q == `RTC_TENTHS_PER_SEC - 4'h1) begin
            gap_ten_q <= 4'h0;
            if (gap_sec_q != 7'h7f) begin
               gap_sec_q <= gap_sec_q + 7'h01;
            end
         end else begin
            gap_ten_q <= gap_ten_q + 4'h1;
         end
      end else begin
         gap_pre_q <= gap_pre_q + 32'h0000_0001;
      end
   end

   assign bus_late = (bus_to_q != 7'h00) && (gap_sec_q >= bus_to_q) &&
                     (gap_pre_q != 32'h0 || gap_ten_q != 4'h0 || gap_sec_q > bus_to_q);

   // ======================================================================
   // Critical situation per mode.
   logic crit;  // Critical situation now.

   assign crit = (mode_q == RTC_BUS_CONTROLLED) ? bus_late : out_of_range;

   // ======================================================================
   // Switching delay timer; restarts whenever the pending change lapses.
   logic        pending;     // A change is waiting for its delay.
   logic [9:0]  need;        // Delay of the pending change.
   logic [31:0] dly_pre_q;   // Cycles within a tenth.
   logic [5:0]  dly_div_q;   // Tenths within one step.
   logic [9:0]  dly_q;       // Elapsed steps.
   logic        step;        // One delay step has passed.
   logic        expired;     // Delay has run out.

   assign pending = thr_mode && !crit &&
                    ((!relay_q && on_cond) || (relay_q && off_cond));
   assign need    = relay_q ? off_dly_q : on_dly_q;
   assign step    = (dly_pre_q == 32'(TENTH_CYCLES - 1)) &&
                    (!minutes_q || dly_div_q == `RTC_TENTHS_PER_MIN_STEP - 6'h01);
   assign expired = dly_q >= need;

   // Counts steps while the change stays pending.
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !pending || expired) begin
         dly_pre_q <= 32'h0000_0000;
         dly_div_q <= 6'h00;
         dly_q     <= 10'h000;
      end else if (dly_pre_q == 32'(TENTH_CYCLES - 1)) begin
         dly_pre_q <= 32'h0000_0000;
         dly_div_q <= step ? 6'h00 : dly_div_q + 6'h01;
         if (step) begin
            dly_q <= dly_q + 10'h001;
         end
      end else begin
         dly_pre_q <= dly_pre_q + 32'h0000_0001;
      end
   end

   // ======================================================================
   // Relay state: alarm reaction first, then mode behaviour.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         relay_q <= 1'b0;
      end else if (crit && alarm_q == RTC_FORCE_ON) begin
         relay_q <= 1'b1;
      end else if (crit && alarm_q == RTC_FORCE_OFF) begin
         relay_q <= 1'b0;
      end else if (crit) begin
         relay_q <= relay_q;
      end else if (mode_q == RTC_BUS_CONTROLLED) begin
         relay_q <= bus_cmd_q;
      end else if (!thr_mode) begin
         relay_q <= 1'b0;
      end else if (pending && expired) begin
         relay_q <= !relay_q;
      end
   end

   // The indicator tracks the relay state in the same cycle.
   assign led_q = relay_q;

   assign relay_out = relay_q;
   assign relay_led = led_q;

   // ======================================================================
   // Read data, captured in the setup phase.
   always_comb begin
      case (paddr)
         `RTC_OFS_CTRL:    rd_mux = {23'h0, zero_base_q, use_peak_q, minutes_q, alarm_q, 1'b0, mode_q};
         `RTC_OFS_THR1:    rd_mux = {{16{thr1_q[15]}}, thr1_q};
         `RTC_OFS_THR2:    rd_mux = {{16{thr2_q[15]}}, thr2_q};
         `RTC_OFS_HYSTERESIS_HALF_WIDTH:    rd_mux = {22'h0, hysteresis_half_width_q};
         `RTC_OFS_DELAY:   rd_mux = {6'h0, off_dly_q, 6'h0, on_dly_q};
         `RTC_OFS_RANGE:   rd_mux = {6'h0, hi_exp_q, 6'h0, lo_exp_q};
         `RTC_OFS_NOMINAL: rd_mux = {nom_max_q, nom_min_q};
         `RTC_OFS_BUSCMD:  rd_mux = {17'h0, bus_to_q, 7'h0, bus_cmd_q};
         `RTC_OFS_STATUS:  rd_mux = {26'h0, pending, bus_late, out_of_range, crit, led_q, relay_q};
         default:          rd_mux = 32'h0000_0000;
      endcase
   end

   // Registers the read word so it is stable through the access phase.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
   end

   // ======================================================================
   // Checks.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   chk_inactive_released: assert property (
      (mode_q == RTC_OUTPUT_INACTIVE && !(crit && alarm_q == RTC_FORCE_ON)) |=> !relay_q)
      else $error("Relay energised in inactive mode.");
   chk_led_tracks_relay: assert property (relay_led == relay_out)
      else $error("LED differs from relay.");
   chk_alarm_force_on: assert property (
      (crit && alarm_q == RTC_FORCE_ON) |=> relay_out)
      else $error("Force-on alarm did not energise relay.");
   chk_alarm_force_off: assert property (
      (crit && alarm_q == RTC_FORCE_OFF) |=> !relay_out)
      else $error("Force-off alarm did not release relay.");
   chk_alarm_keep_state: assert property (
      (crit && alarm_q == RTC_KEEP_STATE) |=> $stable(relay_out))
      else $error("Keep-state alarm changed relay.");
   chk_bus_follows_cmd: assert property (
      (mode_q == RTC_BUS_CONTROLLED && !crit) |=> (relay_out == $past(bus_cmd_q)))
      else $error("Bus mode relay differs from command.");
   chk_rise_needs_cond: assert property (
      ($rose(relay_out) && $past(thr_mode && !crit)) |-> $past(on_cond))
      else $error("Relay energised without switch-on condition.");
   chk_fall_needs_cond: assert property (
      ($fell(relay_out) && $past(thr_mode && !crit)) |-> $past(off_cond))
      else $error("Relay released without switch-off condition.");
   chk_no_early_switch: assert property (
      (pending && !expired) |=> $stable(relay_out) || $past(crit) || !$past(thr_mode))
      else $error("Relay switched before delay elapsed.");
   chk_timer_restart: assert property (!pending |=> (dly_q == 10'h000))
      else $error("Delay timer not restarted.");
   chk_timeout_disabled: assert property ((bus_to_q == 7'h00) |-> !bus_late)
      else $error("Timeout raised while supervision disabled.");

   cov_direct_on: cover property (mode_q == RTC_SINGLE_DIRECT ##1 $rose(relay_out));
   cov_inside_on: cover property (mode_q == RTC_DUAL_INSIDE ##1 $rose(relay_out));
   cov_bus_timeout: cover property ($rose(bus_late));
   cov_crit_force_on: cover property (crit && alarm_q == RTC_FORCE_ON && mode_q == RTC_OUTPUT_INACTIVE);

endmodule // rtc_relay_ctrl

// File: rtc_consts.svh
// Register offsets, field positions, reset values and timing counts of the relay threshold controller.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ==========================================================================
// Register byte offsets.
`define RTC_OFS_CTRL      8'h00
`define RTC_OFS_THR1      8'h04
`define RTC_OFS_THR2      8'h08
`define RTC_OFS_HYSTERESIS_HALF_WIDTH      8'h0c
`define RTC_OFS_DELAY     8'h10
`define RTC_OFS_RANGE     8'h14
`define RTC_OFS_NOMINAL   8'h18
`define RTC_OFS_BUSCMD    8'h1c
`define RTC_OFS_STATUS    8'h20

// ==========================================================================
// Field positions.
`define RTC_CTRL_MODE_LSB   0
`define RTC_CTRL_ALARM_LSB  4
`define RTC_CTRL_MINUTES    6
`define RTC_CTRL_PEAK       7
`define RTC_CTRL_ZEROBASE   8
`define RTC_HI_FIELD_LSB    16
`define RTC_BUS_TIMEOUT_LSB 8

// ==========================================================================
// Setting limits and reset values.
`define RTC_THR_MIN       (-999)
`define RTC_THR_MAX       9999
`define RTC_HYSTERESIS_HALF_WIDTH_MAX      10'h3e7
`define RTC_DELAY_MAX     10'h3e7
`define RTC_LO_EXP_MAX    10'h3e7
`define RTC_HI_EXP_MAX    10'hc7
`define RTC_TIMEOUT_MAX   7'h63
`define RTC_PER_MILLE     1000
`define RTC_NOM_MAX_RST   16'h4e20
`define RTC_NOM_MIN_RST   16'h0fa0

// ==========================================================================
// Timing.
`define RTC_CLK_PERIOD_PS 25000
`define RTC_TENTH_SEC_PS  64'd100000000000
`define RTC_TENTH_CYCLES  (`RTC_TENTH_SEC_PS / `RTC_CLK_PERIOD_PS)
`define RTC_TENTHS_PER_MIN_STEP 6'h3c
`define RTC_TENTHS_PER_SEC      4'ha

`endif

// File: rtc_pkg.sv
// Types shared by the relay threshold controller.
package rtc_pkg;

   // Output operating modes.
   typedef enum logic [2:0] {
      RTC_OUTPUT_INACTIVE = 3'b000,
      RTC_SINGLE_DIRECT   = 3'b001,
      RTC_SINGLE_INVERSE  = 3'b010,
      RTC_DUAL_INSIDE     = 3'b011,
      RTC_DUAL_OUTSIDE    = 3'b100,
      RTC_BUS_CONTROLLED  = 3'b101
   } rtc_mode_t;

   // Relay reaction to a critical situation.
   typedef enum logic [1:0] {
      RTC_KEEP_STATE = 2'b00,
      RTC_FORCE_ON   = 2'b01,
      RTC_FORCE_OFF  = 2'b10
   } rtc_alarm_t;

endpackage

// File: rtc_meas_model.sv
// Model of the measured input source and of the relay output stage.
`timescale 1ns/1ps
module rtc_meas_model (
   input  wire logic               ref_clk,          // System clock.
   input  wire logic signed [15:0] set_value,        // Result asked for by the bench.
   input  wire logic        [15:0] set_level,        // Raw level asked for by the bench.
   input  wire logic               relay_out,        // Relay drive seen.
   input  wire logic               relay_led,        // LED drive seen.
   output logic signed      [15:0] meas_result = '0, // Current result.
   output logic signed      [15:0] meas_peak = '0,   // Held peak, 50 above the result.
   output logic             [15:0] input_level = '0, // Raw input level.
   output int                      led_err = 0       // Cycles with LED apart from relay.
);
   // The source moves its outputs right after each rising edge.
   always @(posedge ref_clk) begin
      meas_result <= set_value;
      meas_peak <= set_value + 16'sh0032;
      input_level <= set_level;
   end
   // The output stage counts settled cycles where the LED disagrees with the relay.
   always @(negedge ref_clk) if (relay_led !== relay_out) led_err++;
endmodule // rtc_meas_model

// File: rtc_relay_ctrl_tb.sv
// Self-checking bench of the relay threshold controller.
`timescale 1ns/1ps
`include "rtc_consts.svh"
module rtc_relay_ctrl_tb;
   import rtc_pkg::*;
   typedef struct {logic [8:0] ctl; logic signed [15:0] v; logic exp;} rtc_row_t;
   logic               ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        [7:0]  paddr = '0;               // Bus address.
   logic        [31:0] pwdata = '0, prdata, rd;  // Bus data and last read.
   logic               pready, pslverr, err, relay_out, relay_led, pk = 1;  // Bus answers, relay, peak flag.
   logic signed [15:0] sv = '0, mr, mp;          // Asked result and model outputs.
   logic        [15:0] lv = 16'h2710, il;        // Asked raw level, inside range.
   int                 n_fail = 0, checks_done = 0, cyc = 0, led_err;
   // Ordinary cases: control word, input value, relay expected; T1=100, T2=300, H=10.
   rtc_row_t rows [15] = '{'{9'h001,111,1}, '{9'h001,95,1}, '{9'h001,89,0}, '{9'h081,70,1},
      '{9'h002,111,0}, '{9'h002,95,0}, '{9'h002,89,1}, '{9'h003,150,1}, '{9'h003,305,1},
      '{9'h003,320,0}, '{9'h004,305,0}, '{9'h004,150,1}, '{9'h004,80,0}, '{9'h004,150,1},
      '{9'h000,150,0}};
   always #12.5 ref_clk = ~ref_clk;
   rtc_relay_ctrl #(.TENTH_CYCLES(4)) rtc_relay_ctrl_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_result(mr), .meas_peak(mp),
      .peak_active(pk), .input_level(il), .relay_out(relay_out), .relay_led(relay_led));
   rtc_meas_model rtc_meas_model_inst (.ref_clk(ref_clk), .set_value(sv), .set_level(lv),
      .relay_out(relay_out), .relay_led(relay_led), .meas_result(mr), .meas_peak(mp),
      .input_level(il), .led_err(led_err));
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0s expected %h seen %h", nm, e, s);
      end
   endtask
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk) penable <= 1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Waits n edges and one more; outputs are read as they stood before that last edge.
   task automatic wt(input int n);
      repeat (n + 1) @(posedge ref_clk);
   endtask
   // A hang is cut short after a ceiling far above the run length.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   // Main sequence.
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1;
      apb(1, `RTC_OFS_THR1, 32'h64);
      apb(1, `RTC_OFS_THR2, 32'h12c);
      apb(1, `RTC_OFS_HYSTERESIS_HALF_WIDTH, 32'ha);
      foreach (rows[i]) begin
         apb(1, `RTC_OFS_CTRL, {23'h0, rows[i].ctl});
         sv <= rows[i].v;
         wt(3);
         chk("relay_row", relay_out, rows[i].exp);
      end
      $display("test rows done");
      pk <= 0;
      apb(1, `RTC_OFS_CTRL, 32'h81);
      sv <= 70;
      wt(3);
      chk("peak_idle", relay_out, 0);
      pk <= 1;
      apb(1, `RTC_OFS_CTRL, 32'h10);
      lv <= 16'h7530;
      wt(3);
      chk("force_on", relay_out, 1);
      apb(1, `RTC_OFS_CTRL, 32'h21);
      wt(3);
      chk("force_off", relay_out, 0);
      lv <= 16'h2710;
      sv <= 100;
      apb(1, `RTC_OFS_DELAY, 32'h2);
      sv <= 150;
      wt(4);
      chk("on_early", relay_out, 0);
      sv <= 100;
      wt(4);
      sv <= 150;
      wt(6);
      chk("on_restart", relay_out, 0);
      wt(8);
      chk("on_late", relay_out, 1);
      apb(1, `RTC_OFS_DELAY, 32'h10000);
      apb(1, `RTC_OFS_CTRL, 32'h41);
      sv <= 50;
      wt(200);
      chk("off_minutes", relay_out, 1);
      wt(60);
      chk("off_late", relay_out, 0);
      $display("test alarm and delay done");
      apb(1, `RTC_OFS_DELAY, 32'h0);
      apb(1, `RTC_OFS_BUSCMD, 32'h1);
      apb(1, `RTC_OFS_CTRL, 32'h5);
      sv <= -500;
      wt(3);
      chk("bus_on", relay_out, 1);
      apb(1, `RTC_OFS_CTRL, 32'h25);
      apb(1, `RTC_OFS_BUSCMD, 32'h101);
      wt(30);
      chk("bus_in_time", relay_out, 1);
      wt(20);
      chk("bus_late", relay_out, 0);
      reset_n <= 0;
      wt(4);
      reset_n <= 1;
      apb(0, `RTC_OFS_BUSCMD, 32'h0);
      chk("bus_cmd_rst", rd, 0);
      chk("relay_rst", relay_out, 0);
      apb(0, 8'h40, 32'h0);
      chk("unmapped_err", err, 1);
      chk("unmapped_data", rd, 0);
      chk("led_follow", led_err == 0, 1);
      $display("test bus and reset done");
      tally_and_finish;
   end
endmodule // rtc_relay_ctrl_tb
